// ### hw/upr_pkg.sv
/*
 * Package for the UART channel 1 pin route block: register indices,
 * byte addresses, reset values, pin positions, mode and drive codes.
 * Assumes a 32-bit APB slave with each 8-bit register in one aligned word.
 */
package upr_pkg;

   localparam int          ADDR_W = 18;
   localparam int          NREG   = 12;

   // register indices as printed; byte address is four times the index
   localparam logic [15:0] IDX_P7_OUTPUT_LATCH  = 16'hF26E;
   localparam logic [15:0] IDX_P7_PIN_DIRECTION = 16'hF26F;
   localparam logic [15:0] IDX_P7_DRIVE_CTL_LO  = 16'hF270;
   localparam logic [15:0] IDX_P7_DRIVE_CTL_HI  = 16'hF271;
   localparam logic [15:0] IDX_P7_FUNC_SEL_LO   = 16'hF272;
   localparam logic [15:0] IDX_P7_FUNC_SEL_HI   = 16'hF273;
   localparam logic [15:0] IDX_P8_OUTPUT_LATCH  = 16'hF2DE;
   localparam logic [15:0] IDX_P8_PIN_DIRECTION = 16'hF2DF;
   localparam logic [15:0] IDX_P8_DRIVE_CTL_LO  = 16'hF2E0;
   localparam logic [15:0] IDX_P8_DRIVE_CTL_HI  = 16'hF2E1;
   localparam logic [15:0] IDX_P8_FUNC_SEL_LO   = 16'hF2E2;
   localparam logic [15:0] IDX_P8_FUNC_SEL_HI   = 16'hF2E3;

   // slots inside the register array
   localparam int          R_LATCH = 0;
   localparam int          R_DIR   = 1;
   localparam int          R_CON0  = 2;
   localparam int          R_CON1  = 3;
   localparam int          R_MOD0  = 4;
   localparam int          R_MOD1  = 5;
   localparam int          P8_BASE = 6;

   localparam logic [15:0] REG_IDX [NREG] = '{
      IDX_P7_OUTPUT_LATCH, IDX_P7_PIN_DIRECTION, IDX_P7_DRIVE_CTL_LO,
      IDX_P7_DRIVE_CTL_HI, IDX_P7_FUNC_SEL_LO,   IDX_P7_FUNC_SEL_HI,
      IDX_P8_OUTPUT_LATCH, IDX_P8_PIN_DIRECTION, IDX_P8_DRIVE_CTL_LO,
      IDX_P8_DRIVE_CTL_HI, IDX_P8_FUNC_SEL_LO,   IDX_P8_FUNC_SEL_HI};

   localparam logic [7:0]  RST_PORT_REG = 8'h00;
   localparam logic [7:0]  P7_IMPL_MASK = 8'h1F;
   localparam int          P7_W         = 5;
   localparam int          P8_W         = 8;
   localparam int          TX_PIN       = 5;
   localparam int          RX_PIN       = 2;

   // {func_sel_hi, func_sel_lo}
   localparam logic [1:0]  MODE_SECONDARY = 2'h1;
   // {drive_ctl_hi, drive_ctl_lo}
   localparam logic [1:0]  DRV_HIZ        = 2'h0;
   localparam logic [1:0]  DRV_PCH_OD     = 2'h1;
   localparam logic [1:0]  DRV_NCH_OD     = 2'h2;
   localparam logic [1:0]  DRV_CMOS       = 2'h3;
   localparam logic        DIR_OUT        = 1'h0;
   localparam logic        DIR_IN         = 1'h1;
   localparam logic        RX_IDLE        = 1'h1;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RESP = 3'b010,
      ST_DONE = 3'b100
   } upr_apb_e;

endpackage

// ### hw/upr_pin_sync.sv
/*
 * Three-stage input synchroniser with agreement filter for port pins.
 * Assumes asynchronous pin levels; output changes only once stages two
 * and three agree.
 */
`timescale 1ns/1ps
`default_nettype none

module upr_pin_sync #(
   parameter int           W   = 8,
   parameter logic [W-1:0] RST = '0
) (
   input  wire logic         clk_i,  // block clock
   input  wire logic         nrst_i, // async reset, active low
   input  wire logic [W-1:0] d_i,    // raw pin levels
   output logic      [W-1:0] q_o     // filtered levels
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] filt;
   } upr_sync_s;

   upr_sync_s st_q;
   upr_sync_s st_d;

   always_comb begin
      st_d      = st_q;
      st_d.s1   = d_i;
      st_d.s2   = st_q.s1;
      st_d.s3   = st_q.s2;
      // first stage feeds only the second; filter looks at stages two and three
      st_d.filt = (~(st_q.s2 ^ st_q.s3) & st_q.s3) | ((st_q.s2 ^ st_q.s3) & st_q.filt);
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_q <= '{s1: RST, s2: RST, s3: RST, filt: RST};
      end else begin
         st_q <= st_d;
      end
   end

   assign q_o = st_q.filt;

endmodule

`default_nettype wire

// ### hw/upr_pin_route.sv
/*
 * Port 7 / port 8 pin function, drive and data registers over APB, with
 * UART channel 1 routed half-duplex: transmit on port 8 pin 5, receive
 * on port 7 pin 2.
 * Assumes the UART engine runs on the same clock; pads resolve the wire
 * from out/oe/pull outputs.
 */
// Functional notes
// - tx pin func select 01 routes UART1 transmit to port 8 pin 5
// - tx pin drive 11 with direction 0 drives push-pull CMOS
// - tx pin latch bit has no effect while transmit is routed
// - rx pin func select 01 with direction 1 routes port 7 pin 2 to UART1 receive
// - rx pin direction 1 makes port 7 pin 2 an input
// - rx pin latch bit has no effect on reception
// - tx and rx pins together form one half-duplex UART1 link
`timescale 1ns/1ps
`default_nettype none

module upr_pin_route
   import upr_pkg::*;
(
   input  wire logic              REF_CLK_I,     // 40 MHz clock
   input  wire logic              NRST_I,        // async reset, active low
   input  wire logic              PSEL_I,        // apb select
   input  wire logic              PENABLE_I,     // apb enable
   input  wire logic              PWRITE_I,      // apb write
   input  wire logic [ADDR_W-1:0] PADDR_I,       // apb byte address
   input  wire logic [31:0]       PWDATA_I,      // apb write data
   output logic      [31:0]       PRDATA_O,      // apb read data
   output logic                   PREADY_O,      // apb ready
   output logic                   PSLVERR_O,     // apb error, unmapped
   input  wire logic              SER1_TX_I,     // uart1 transmit from engine
   output logic                   SER1_RX_O,     // uart1 receive to engine
   input  wire logic [P7_W-1:0]   PORT7_IN_I,    // port 7 pad levels
   output logic      [P7_W-1:0]   PORT7_OUT_O,   // port 7 pad data
   output logic      [P7_W-1:0]   PORT7_OE_O,    // port 7 pad drive enable
   output logic      [P7_W-1:0]   PORT7_PU_O,    // port 7 pull-up enable
   output logic      [P7_W-1:0]   PORT7_PD_O,    // port 7 pull-down enable
   input  wire logic [P8_W-1:0]   PORT8_IN_I,    // port 8 pad levels
   output logic      [P8_W-1:0]   PORT8_OUT_O,   // port 8 pad data
   output logic      [P8_W-1:0]   PORT8_OE_O,    // port 8 pad drive enable
   output logic      [P8_W-1:0]   PORT8_PU_O,    // port 8 pull-up enable
   output logic      [P8_W-1:0]   PORT8_PD_O     // port 8 pull-down enable
);

   typedef struct packed {
      upr_apb_e             st;
      logic                 ready;
      logic                 slverr;
      logic [31:0]          rdata;
      logic [3:0]           widx;
      logic                 whit;
      logic [NREG-1:0][7:0] regs;
      logic [P7_W-1:0]      p7_out;
      logic [P7_W-1:0]      p7_oe;
      logic [P7_W-1:0]      p7_pu;
      logic [P7_W-1:0]      p7_pd;
      logic [P8_W-1:0]      p8_out;
      logic [P8_W-1:0]      p8_oe;
      logic [P8_W-1:0]      p8_pu;
      logic [P8_W-1:0]      p8_pd;
      logic                 rx;
   } upr_state_s;

   upr_state_s      st_q;
   upr_state_s      st_d;
   logic [P7_W-1:0] p7_pin;
   logic [P8_W-1:0] p8_pin;

   upr_pin_sync #(
      .W   (P7_W),
      .RST ({P7_W{1'b1}})
   ) u_p7_sync (
      .clk_i  (REF_CLK_I),
      .nrst_i (NRST_I),
      .d_i    (PORT7_IN_I),
      .q_o    (p7_pin)
   );

   upr_pin_sync #(
      .W   (P8_W),
      .RST ({P8_W{1'b1}})
   ) u_p8_sync (
      .clk_i  (REF_CLK_I),
      .nrst_i (NRST_I),
      .d_i    (PORT8_IN_I),
      .q_o    (p8_pin)
   );

   // address decode shared by read and write; misaligned counts as a miss
   function automatic logic [4:0] decode(input logic [ADDR_W-1:0] a);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 0; i < NREG; i++) begin
         if (a == ADDR_W'({REG_IDX[i], 2'h0})) begin
            r = {1'b1, 4'(i)};
         end
      end
      return r;
   endfunction

   // per-pin pad control: returns {pd, pu, oe} for eight pins
   function automatic logic [23:0] pad_ctl(input logic [7:0] dir, input logic [7:0] c1,
                                           input logic [7:0] c0, input logic [7:0] v);
      logic [7:0] oe;
      logic [7:0] pu;
      logic [7:0] pd;
      oe = 8'h00;
      pu = 8'h00;
      pd = 8'h00;
      for (int i = 0; i < 8; i++) begin
         if (dir[i] == DIR_OUT) begin
            case ({c1[i], c0[i]})
               DRV_CMOS:   oe[i] = 1'b1;
               DRV_PCH_OD: oe[i] = v[i];
               DRV_NCH_OD: oe[i] = ~v[i];
               default:    oe[i] = 1'b0;
            endcase
         end else begin
            // input modes are free for software; the pad only gets pulls
            pd[i] = ({c1[i], c0[i]} == DRV_PCH_OD);
            pu[i] = ({c1[i], c0[i]} == DRV_NCH_OD);
         end
      end
      return {pd, pu, oe};
   endfunction

   logic [7:0]  p7_lat;
   logic [7:0]  p7_dir;
   logic [7:0]  p7_c0;
   logic [7:0]  p7_c1;
   logic [7:0]  p7_m0;
   logic [7:0]  p7_m1;
   logic [7:0]  p8_lat;
   logic [7:0]  p8_dir;
   logic [7:0]  p8_c0;
   logic [7:0]  p8_c1;
   logic [7:0]  p8_m0;
   logic [7:0]  p8_m1;
   logic        tx_sec;
   logic        rx_sec;
   logic        rx_ok;
   logic [4:0]  dec;
   logic [7:0]  p8_val;
   logic [23:0] p7_pad;
   logic [23:0] p8_pad;
   logic [7:0]  rd_byte;

   assign p7_lat = st_q.regs[R_LATCH];
   assign p7_dir = st_q.regs[R_DIR];
   assign p7_c0  = st_q.regs[R_CON0];
   assign p7_c1  = st_q.regs[R_CON1];
   assign p7_m0  = st_q.regs[R_MOD0];
   assign p7_m1  = st_q.regs[R_MOD1];
   assign p8_lat = st_q.regs[P8_BASE + R_LATCH];
   assign p8_dir = st_q.regs[P8_BASE + R_DIR];
   assign p8_c0  = st_q.regs[P8_BASE + R_CON0];
   assign p8_c1  = st_q.regs[P8_BASE + R_CON1];
   assign p8_m0  = st_q.regs[P8_BASE + R_MOD0];
   assign p8_m1  = st_q.regs[P8_BASE + R_MOD1];

   assign tx_sec = ({p8_m1[TX_PIN], p8_m0[TX_PIN]} == MODE_SECONDARY);
   assign rx_sec = ({p7_m1[RX_PIN], p7_m0[RX_PIN]} == MODE_SECONDARY);
   assign rx_ok  = rx_sec && (p7_dir[RX_PIN] == DIR_IN);

   always_comb begin
      st_d    = st_q;
      dec     = decode(PADDR_I);
      rd_byte = 8'h00;
      // latch bit replaced by engine output while routed, per pin only
      p8_val         = p8_lat;
      p8_val[TX_PIN] = tx_sec ? SER1_TX_I : p8_lat[TX_PIN];
      p7_pad = pad_ctl(p7_dir, p7_c1, p7_c0, p7_lat);
      p8_pad = pad_ctl(p8_dir, p8_c1, p8_c0, p8_val);

      // input pins read their pad level, output pins their latch
      if (dec[4]) begin
         rd_byte = st_q.regs[dec[3:0]];
         if (dec[3:0] == 4'(R_LATCH)) begin
            rd_byte = ((p7_lat & ~p7_dir) | ({3'h0, p7_pin} & p7_dir)) & P7_IMPL_MASK;
         end else if (dec[3:0] == 4'(P8_BASE + R_LATCH)) begin
            rd_byte = (p8_lat & ~p8_dir) | (p8_pin & p8_dir);
         end
      end

      case (st_q.st)
         ST_IDLE: begin
            // one wait state keeps pready and prdata straight from flops
            if (PSEL_I && PENABLE_I) begin
               st_d.st     = ST_RESP;
               st_d.ready  = 1'b1;
               st_d.slverr = ~dec[4];
               st_d.rdata  = PWRITE_I ? 32'h0000_0000 : {24'h00_0000, rd_byte};
               st_d.widx   = dec[3:0];
               st_d.whit   = dec[4] & PWRITE_I;
            end
         end
         ST_RESP: begin
            // write lands at the edge that samples pready high
            if (st_q.whit) begin
               st_d.regs[st_q.widx] = PWDATA_I[7:0];
               if (st_q.widx < 4'(P8_BASE)) begin
                  st_d.regs[st_q.widx] = PWDATA_I[7:0] & P7_IMPL_MASK;
               end
            end
            st_d.st     = ST_DONE;
            st_d.ready  = 1'b0;
            st_d.slverr = 1'b0;
            st_d.whit   = 1'b0;
         end
         ST_DONE: begin
            // master drops penable after ready; wait out that cycle
            st_d.st = ST_IDLE;
         end
         default: begin
            st_d.st    = ST_IDLE;
            st_d.ready = 1'b0;
         end
      endcase

      st_d.p7_out = p7_lat[P7_W-1:0];
      st_d.p7_oe  = p7_pad[P7_W-1:0];
      st_d.p7_pu  = p7_pad[8 +: P7_W];
      st_d.p7_pd  = p7_pad[16 +: P7_W];
      st_d.p8_out = p8_val;
      st_d.p8_oe  = p8_pad[7:0];
      st_d.p8_pu  = p8_pad[15:8];
      st_d.p8_pd  = p8_pad[23:16];
      // latch bit never reaches the receiver; idle high when unrouted
      st_d.rx     = rx_ok ? p7_pin[RX_PIN] : RX_IDLE;
   end

   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         st_q        <= '0;
         st_q.st     <= ST_IDLE;
         st_q.regs   <= {NREG{RST_PORT_REG}};
         st_q.rx     <= RX_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   assign PRDATA_O    = st_q.rdata;
   assign PREADY_O    = st_q.ready;
   assign PSLVERR_O   = st_q.slverr;
   assign SER1_RX_O   = st_q.rx;
   assign PORT7_OUT_O = st_q.p7_out;
   assign PORT7_OE_O  = st_q.p7_oe;
   assign PORT7_PU_O  = st_q.p7_pu;
   assign PORT7_PD_O  = st_q.p7_pd;
   assign PORT8_OUT_O = st_q.p8_out;
   assign PORT8_OE_O  = st_q.p8_oe;
   assign PORT8_PU_O  = st_q.p8_pu;
   assign PORT8_PD_O  = st_q.p8_pd;

   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!NRST_I);

   logic tx_cmos;
   logic commit;
   assign tx_cmos = (p8_dir[TX_PIN] == DIR_OUT) && ({p8_c1[TX_PIN], p8_c0[TX_PIN]} == DRV_CMOS);
   assign commit  = (st_q.st == ST_RESP) && st_q.whit;

   property p_tx_route;
      tx_sec |=> (PORT8_OUT_O[TX_PIN] == $past(SER1_TX_I));
   endproperty
   a_tx_route: assert property (p_tx_route)
      else $error("tx pin does not follow uart transmit");

   property p_tx_cmos;
      tx_cmos |=> PORT8_OE_O[TX_PIN] ##0 (PORT8_PU_O[TX_PIN] == 1'b0);
   endproperty
   a_tx_cmos: assert property (p_tx_cmos)
      else $error("tx pin not driven push-pull");

   property p_tx_latch_ignored;
      (tx_sec && (p8_lat[TX_PIN] != SER1_TX_I)) |=> (PORT8_OUT_O[TX_PIN] != $past(p8_lat[TX_PIN]));
   endproperty
   a_tx_latch_ignored: assert property (p_tx_latch_ignored)
      else $error("tx pin shows latch bit while routed");

   property p_rx_route;
      (rx_ok && $stable(p7_pin[RX_PIN])) [*2] |=> (SER1_RX_O == $past(p7_pin[RX_PIN]));
   endproperty
   a_rx_route: assert property (p_rx_route)
      else $error("receive input does not follow rx pin");

   property p_rx_input;
      (p7_dir[RX_PIN] == DIR_IN) |=> !PORT7_OE_O[RX_PIN];
   endproperty
   a_rx_input: assert property (p_rx_input)
      else $error("rx pin driven while set as input");

   property p_rx_latch_ignored;
      (rx_ok && (p7_lat[RX_PIN] != p7_pin[RX_PIN])) |=> (SER1_RX_O != $past(p7_lat[RX_PIN]));
   endproperty
   a_rx_latch_ignored: assert property (p_rx_latch_ignored)
      else $error("receive input shows latch bit");

   property p_half_duplex;
      (tx_sec && tx_cmos && rx_ok) |=> (PORT8_OE_O[TX_PIN] && !PORT7_OE_O[RX_PIN]
                                        && (PORT8_OUT_O[TX_PIN] == $past(SER1_TX_I)));
   endproperty
   a_half_duplex: assert property (p_half_duplex)
      else $error("tx and rx pins do not form one link");

   property p_other_pins_kept;
      (commit && (st_q.widx < 4'(P8_BASE)))
         |=> (st_q.regs[NREG-1:P8_BASE] == $past(st_q.regs[NREG-1:P8_BASE]));
   endproperty
   a_other_pins_kept: assert property (p_other_pins_kept)
      else $error("port 7 write disturbed port 8 registers");

endmodule

`default_nettype wire

// ### sim/upr_serial_peer.sv
/*
 * Behavioural serial peer on the UART1 receive pin.
 * Assumes the bench clock; each bit is held a caller-chosen number of edges.
 */
`timescale 1ns/1ps
`default_nettype none

module upr_serial_peer (
   input  wire logic clk_i,  // bench clock
   output logic      rx_o    // line into the rx pin
);
   // idle high between frames, like a stop bit
   initial rx_o = 1'b1;

   // slow or prompt peers differ only in hold length
   task automatic put_bit(input logic b, input int hold);
      @(posedge clk_i);
      rx_o <= b;
      repeat (hold) @(posedge clk_i);
   endtask
endmodule

`default_nettype wire

// ### sim/uart1_pin_route_port7_port8_tb.sv
/*
 * Self-checking bench for the UART1 pin route: APB registers, transmit on
 * port 8 pin 5, receive on port 7 pin 2.
 * Assumes upr_pkg and the serial peer model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module uart1_pin_route_port7_port8_tb;
   import upr_pkg::*;

   logic              ref_clk = 1'b0;
   logic              nrst_n  = 1'b0;
   logic              psel    = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite  = 1'b0;
   logic [ADDR_W-1:0] paddr   = '0;
   logic [31:0]       pwdata  = '0;
   logic              ser1_tx = 1'b1;
   logic [P7_W-1:0]   p7_ext  = '0;
   logic [P8_W-1:0]   p8_ext  = '0;
   wire  [31:0]       prdata;
   wire               pready, pslverr, ser1_rx, rx_line;
   wire  [P7_W-1:0]   p7_in, p7_out, p7_oe, p7_pu, p7_pd;
   wire  [P8_W-1:0]   p8_in, p8_out, p8_oe, p8_pu, p8_pd;
   logic [7:0]        mdl [NREG];
   int                error_cnt = 0;
   int                samples_checked = 0;
   int                cyc = 0;

   // pad wire: the driver wins, else the outside world
   assign p7_in = (p7_oe & p7_out) | (~p7_oe & {p7_ext[4:3], rx_line, p7_ext[1:0]});
   assign p8_in = (p8_oe & p8_out) | (~p8_oe & p8_ext);

   always #12.5 ref_clk = ~ref_clk;

   upr_pin_route DUT (
      .REF_CLK_I   (ref_clk),
      .NRST_I      (nrst_n),
      .PSEL_I      (psel),
      .PENABLE_I   (penable),
      .PWRITE_I    (pwrite),
      .PADDR_I     (paddr),
      .PWDATA_I    (pwdata),
      .PRDATA_O    (prdata),
      .PREADY_O    (pready),
      .PSLVERR_O   (pslverr),
      .SER1_TX_I   (ser1_tx),
      .SER1_RX_O   (ser1_rx),
      .PORT7_IN_I  (p7_in),
      .PORT7_OUT_O (p7_out),
      .PORT7_OE_O  (p7_oe),
      .PORT7_PU_O  (p7_pu),
      .PORT7_PD_O  (p7_pd),
      .PORT8_IN_I  (p8_in),
      .PORT8_OUT_O (p8_out),
      .PORT8_OE_O  (p8_oe),
      .PORT8_PU_O  (p8_pu),
      .PORT8_PD_O  (p8_pd)
   );

   upr_serial_peer peer (
      .clk_i (ref_clk),
      .rx_o  (rx_line)
   );

   task automatic wrap_up();
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 40000) begin
         error_cnt++;
         wrap_up();
      end
   end

   task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string msg);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
      int n;
      @(posedge ref_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {idx, 2'b00};
      pwdata  <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      chk({32'h0, pready}, 33'h1, "apb answer");
   endtask

   // upper data bits random: only the low byte may land
   task automatic wreg(input int s, input logic [7:0] v);
      logic [31:0] rd;
      logic        er;
      mdl[s] = (s < P8_BASE) ? (v & P7_IMPL_MASK) : v;
      apb(1'b1, REG_IDX[s], {24'($urandom), v}, rd, er);
   endtask

   task automatic setb(input int s, input int b, input logic v);
      logic [7:0] t;
      t = mdl[s];
      t[b] = v;
      wreg(s, t);
   endtask

   task automatic chk_all();
      logic [31:0] rd;
      logic        er;
      logic [7:0]  e;
      for (int s = 0; s < NREG; s++) begin
         apb(1'b0, REG_IDX[s], '0, rd, er);
         e = mdl[s];
         if (s == R_LATCH)
            e = (e & ~mdl[R_DIR]) | ({3'h0, p7_in} & mdl[R_DIR]);
         if (s == P8_BASE + R_LATCH)
            e = (e & ~mdl[P8_BASE + R_DIR]) | (p8_in & mdl[P8_BASE + R_DIR]);
         chk({er, rd}, {9'h0, 16'h0, e}, "register readback");
      end
   endtask

   // {oe, out} for an output pin driven from its latch
   function automatic logic [1:0] exp_drv(input logic [1:0] code, input logic d);
      case (code)
         DRV_CMOS:   return {1'b1, d};
         DRV_PCH_OD: return {d, d};
         DRV_NCH_OD: return {~d, d};
         default:    return {1'b0, d};
      endcase
   endfunction

   // pad controls of one port from the model; a routed tx pin carries the engine level
   task automatic chk_pads(input int b, input int w);
      logic [1:0] c;
      logic [1:0] m;
      logic [1:0] e;
      logic       d;
      logic [3:0] g;
      for (int i = 0; i < w; i++) begin
         c = {mdl[b + R_CON1][i], mdl[b + R_CON0][i]};
         m = {mdl[b + R_MOD1][i], mdl[b + R_MOD0][i]};
         d = mdl[b + R_LATCH][i];
         if (b == P8_BASE && i == TX_PIN && m == MODE_SECONDARY)
            d = ser1_tx;
         e = exp_drv(c, d);
         if (b == P8_BASE)
            g = {p8_oe[i], p8_out[i], p8_pu[i], p8_pd[i]};
         else
            g = {p7_oe[i], p7_out[i], p7_pu[i], p7_pd[i]};
         if (mdl[b + R_DIR][i] == DIR_IN)
            chk({29'h0, g}, {29'h0, 1'b0, d, c == DRV_NCH_OD, c == DRV_PCH_OD}, "input pad");
         else
            chk({29'h0, g}, {29'h0, e, 2'h0}, "output pad");
      end
   endtask

   task automatic send_frame(input logic [7:0] d);
      logic [9:0] f;
      f = {1'b1, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         peer.put_bit(f[i], 7 + int'($urandom % 6));
         chk({32'h0, ser1_rx}, {32'h0, f[i]}, "rx bit");
      end
   endtask

   initial begin
      logic [31:0] rd;
      logic        er;
      logic [1:0]  e2;
      logic        lt;
      void'($urandom(76242));
      p7_ext = P7_W'($urandom);
      p8_ext = P8_W'($urandom);
      for (int s = 0; s < NREG; s++)
         mdl[s] = RST_PORT_REG;
      repeat (3) @(posedge ref_clk);
      nrst_n <= 1'b1;
      chk_all();
      apb(1'b0, 16'hF2E4, '0, rd, er);
      chk({er, rd}, {1'b1, 32'h0}, "unmapped read");
      apb(1'b1, 16'hF2E4, 32'hFF, rd, er);
      chk({32'h0, er}, 33'h1, "unmapped write");
      for (int s = 0; s < NREG; s++)
         wreg(s, 8'($urandom));
      chk_all();
      chk_pads(0, P7_W);
      chk_pads(P8_BASE, P8_W);
      setb(P8_BASE + R_MOD1, TX_PIN, 1'b0);
      setb(P8_BASE + R_MOD0, TX_PIN, 1'b1);
      setb(P8_BASE + R_CON1, TX_PIN, 1'b1);
      setb(P8_BASE + R_CON0, TX_PIN, 1'b1);
      setb(P8_BASE + R_DIR, TX_PIN, DIR_OUT);
      setb(P8_BASE + R_MOD1, 4, 1'b0);
      setb(P8_BASE + R_MOD0, 4, 1'b0);
      setb(P8_BASE + R_DIR, 4, DIR_OUT);
      for (int k = 0; k < 2; k++) begin
         setb(P8_BASE + R_LATCH, TX_PIN, k[0]);
         @(posedge ref_clk);
         lt = ser1_tx;
         repeat (24) begin
            @(posedge ref_clk);
            chk({32'h0, p8_out[TX_PIN]}, {32'h0, lt}, "tx level");
            chk({32'h0, p8_oe[TX_PIN]}, 33'h1, "tx drive");
            lt = ser1_tx;
            ser1_tx <= 1'($urandom);
         end
         e2 = exp_drv({mdl[P8_BASE + R_CON1][4], mdl[P8_BASE + R_CON0][4]},
                      mdl[P8_BASE + R_LATCH][4]);
         chk({31'h0, p8_oe[4], p8_oe[4] & p8_out[4]}, {31'h0, e2[1], &e2}, "pin 4");
      end
      // engine level opposite the latch, so falling back to the latch is visible
      ser1_tx <= ~mdl[P8_BASE + R_LATCH][TX_PIN];
      setb(P8_BASE + R_MOD0, TX_PIN, 1'b0);
      repeat (2) @(posedge ref_clk);
      chk({32'h0, p8_out[TX_PIN]}, {32'h0, mdl[P8_BASE + R_LATCH][TX_PIN]}, "tx off");
      setb(R_MOD1, RX_PIN, 1'b0);
      setb(R_MOD0, RX_PIN, 1'b1);
      setb(R_DIR, RX_PIN, DIR_IN);
      for (int c = 0; c < 4; c++) begin
         setb(R_CON1, RX_PIN, c[1]);
         setb(R_CON0, RX_PIN, c[0]);
         setb(R_LATCH, RX_PIN, ~c[0]);
         @(posedge ref_clk);
         chk({31'h0, p7_pu[RX_PIN], p7_pd[RX_PIN]}, {31'h0, c == 2, c == 1}, "rx pull");
         send_frame(8'($urandom));
      end
      setb(R_DIR, RX_PIN, DIR_OUT);
      peer.put_bit(1'b0, 8);
      chk({32'h0, ser1_rx}, {32'h0, RX_IDLE}, "rx unrouted");
      peer.put_bit(1'b1, 8);
      chk_all();
      chk_pads(0, P7_W);
      chk_pads(P8_BASE, P8_W);
      wrap_up();
   end
endmodule

`default_nettype wire
